// ---- inc/fbs_pkg.sv ----
// Shared constants and types for the fieldbus slave configuration and status block.
// Assumes a 250 MHz reference clock and a 32-bit AXI4-Lite register bus.
package fbs_pkg;
	localparam int unsigned CLK_HZ        = 250_000_000;
	localparam int unsigned BLINK_FAST_HZ = 4;
	localparam int unsigned HALF_FAST_CYC = CLK_HZ / (2 * BLINK_FAST_HZ);
	localparam int unsigned NUM_RATES     = 10;
	localparam int unsigned RATE_BPS [NUM_RATES] = '{9_600, 19_200, 45_450, 93_750, 187_500,
		500_000, 1_500_000, 3_000_000, 6_000_000, 12_000_000};
	localparam int unsigned RUN_W         = 17;
	localparam int unsigned EDGE_WIN      = 32;
	localparam int unsigned CAP_DELAY     = 4;
	localparam logic [3:0]  DIGIT_MAX     = 4'h9;
	localparam logic [6:0]  TENS_WEIGHT   = 7'h0a;
	localparam logic [6:0]  NODE_MIN      = 7'h01;
	localparam logic [6:0]  NODE_MAX      = 7'h63;
	// Register map
	localparam int unsigned AXI_AW        = 4;
	localparam logic [3:0]  OFS_STATUS    = 4'h0;
	localparam logic [3:0]  OFS_CTRL      = 4'h4;
	localparam logic [3:0]  OFS_FAULT     = 4'h8;
	localparam logic [3:0]  OFS_DIAG      = 4'hc;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	// Status fields
	localparam int unsigned ST_NODE_LSB   = 0;
	localparam int unsigned ST_NODE_OK    = 7;
	localparam int unsigned ST_RATE_LSB   = 8;
	localparam int unsigned ST_RATE_LOCK  = 12;
	localparam int unsigned ST_CAPTURED   = 13;
	// Control, fault and diagnostic fields
	localparam int unsigned CT_INIT_DONE  = 0;
	localparam int unsigned CT_ONLINE     = 1;
	localparam int unsigned CT_INSTALL    = 2;
	localparam int unsigned FL_ASIC_FLASH = 0;
	localparam int unsigned FL_RAM        = 1;
	localparam int unsigned FL_DPRAM      = 2;
	localparam int unsigned DG_IO_SIZE    = 0;
	localparam int unsigned DG_USER_PRM   = 1;
	localparam int unsigned DG_CHIP_EN    = 2;
	localparam logic [2:0]  CTRL_RST      = 3'h0;
	localparam logic [2:0]  FAULT_RST     = 3'h0;
	localparam logic [2:0]  DIAG_RST      = 3'h0;

	typedef enum logic [0:0] {CAP_WAIT, CAP_HELD} fbs_cap_t;

	typedef struct packed {
		logic status_red;
		logic status_green;
		logic diag_red;
		logic online_green;
		logic offline_red;
	} fbs_led_t;
endpackage

// ---- hw/fbs_top.sv ----
// Fieldbus slave configuration and status: bit-rate detection, node address, indicator LEDs.
// Assumes switches and bus line are asynchronous pins; software drives status over AXI4-Lite.
//
// Contract
// - Detect one of ten bit rates automatically
// - Node address is ten times left plus right
// - Address captured once at start-up only
// - Status red 2 Hz on chip/flash fault
// - Status green 2 Hz before initialisation done
// - Status green 1 Hz when operating normally
// - Status red 1 Hz on RAM fault
// - Status red 4 Hz on dual-port RAM fault
// - Hardware faults clear only by power cycle
// - Diagnostics red 1 Hz on I/O size mismatch
// - Diagnostics red 2 Hz on parameter mismatch
// - Diagnostics red 4 Hz on enable failure, else dark
// - On-line green lit while on-line
// - Off-line red lit while off-line
// - Both line indicators flash on address fault
// - Slave only, never starts bus traffic
module fbs_top #(
	parameter int unsigned HALF_FAST = fbs_pkg::HALF_FAST_CYC
) (
	// Clock and reset
	input  wire logic                        REF_CLK,
	input  wire logic                        RSTN,
	// AXI4-Lite slave
	input  wire logic [fbs_pkg::AXI_AW-1:0]  S_AXI_AWADDR,
	input  wire logic                        S_AXI_AWVALID,
	output logic                             S_AXI_AWREADY,
	input  wire logic [31:0]                 S_AXI_WDATA,
	input  wire logic [3:0]                  S_AXI_WSTRB,
	input  wire logic                        S_AXI_WVALID,
	output logic                             S_AXI_WREADY,
	output logic [1:0]                       S_AXI_BRESP,
	output logic                             S_AXI_BVALID,
	input  wire logic                        S_AXI_BREADY,
	input  wire logic [fbs_pkg::AXI_AW-1:0]  S_AXI_ARADDR,
	input  wire logic                        S_AXI_ARVALID,
	output logic                             S_AXI_ARREADY,
	output logic [31:0]                      S_AXI_RDATA,
	output logic [1:0]                       S_AXI_RRESP,
	output logic                             S_AXI_RVALID,
	input  wire logic                        S_AXI_RREADY,
	// Pins
	input  wire logic [3:0]                  SW_TENS,
	input  wire logic [3:0]                  SW_UNITS,
	input  wire logic                        BUS_RX,
	output fbs_pkg::fbs_led_t                LED
);
	import fbs_pkg::*;

	function automatic logic [3:0] rate_of(input logic [RUN_W-1:0] run);
		logic [3:0] idx;
		idx = 4'h0;
		for (int i = 0; i < NUM_RATES; i++) begin
			// Run shorter than three quarters of a bit time means a faster rate
			if (4 * int'(run) < 3 * (CLK_HZ / RATE_BPS[i]) && idx < 4'(NUM_RATES - 1))
				idx = idx + 4'h1;
		end
		return idx;
	endfunction

	function automatic logic reg_hit(input logic [AXI_AW-1:0] a);
		return a == OFS_STATUS || a == OFS_CTRL || a == OFS_FAULT || a == OFS_DIAG;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [8:0] sync1_r;
	logic [8:0] sync2_r;
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			// Line bit resets to its idle high, else a false edge follows reset
			sync1_r <= 9'h100;
			sync2_r <= 9'h100;
		end else begin
			sync1_r <= {BUS_RX, SW_TENS, SW_UNITS};
			sync2_r <= sync1_r;
		end
	end
	logic       rx_s;
	logic [3:0] tens_s;
	logic [3:0] units_s;
	assign {rx_s, tens_s, units_s} = sync2_r;

	////////////////////////////////////////////////////////////////////////////
	// Node address capture
	fbs_cap_t   cap_r;
	logic [2:0] cap_cnt_r;
	logic [6:0] node_r;
	logic       node_ok_r;
	logic [6:0] node_nxt;
	assign node_nxt = 7'(TENS_WEIGHT * 7'(tens_s)) + 7'(units_s);

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			cap_r     <= CAP_WAIT;
			cap_cnt_r <= 3'h0;
			node_r    <= 7'h0;
			node_ok_r <= 1'b0;
		end else begin
			case (cap_r)
				CAP_WAIT: begin
					cap_cnt_r <= cap_cnt_r + 3'h1;
					// Let the synchronisers fill before sampling
					if (cap_cnt_r == 3'(CAP_DELAY - 1)) begin
						cap_r     <= CAP_HELD;
						node_r    <= node_nxt;
						node_ok_r <= tens_s <= DIGIT_MAX && units_s <= DIGIT_MAX
							&& node_nxt >= NODE_MIN && node_nxt <= NODE_MAX;
					end
				end
				CAP_HELD: cap_r <= CAP_HELD;
				default: cap_r <= CAP_WAIT;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bit-rate detection: shortest run over a window of edges
	// The master fixes one rate; a change is followed on the next window
	logic             rx_d_r;
	logic [RUN_W-1:0] run_r;
	logic [RUN_W-1:0] min_r;
	logic [5:0]       edges_r;
	logic [3:0]       rate_r;
	logic             lock_r;
	logic             rx_edge;
	assign rx_edge = rx_s != rx_d_r;

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			rx_d_r  <= 1'b1;
			run_r   <= '0;
			min_r   <= '1;
			edges_r <= 6'h0;
			rate_r  <= 4'h0;
			lock_r  <= 1'b0;
		end else begin
			rx_d_r <= rx_s;
			if (rx_edge) begin
				run_r <= '0;
				if (edges_r == 6'(EDGE_WIN - 1)) begin
					edges_r <= 6'h0;
					min_r   <= '1;
					rate_r  <= rate_of(run_r < min_r ? run_r : min_r);
					lock_r  <= 1'b1;
				end else begin
					edges_r <= edges_r + 6'h1;
					if (run_r < min_r && edges_r != 6'h0)
						min_r <= run_r;
				end
			end else if (run_r != '1) begin
				run_r <= run_r + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Shared blink divider: 4, 2 and 1 Hz, all 50 percent duty
	logic [31:0] div_r;
	logic [2:0]  blink_r;
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			div_r   <= 32'h0;
			blink_r <= 3'h0;
		end else if (div_r == HALF_FAST - 1) begin
			div_r   <= 32'h0;
			blink_r <= blink_r + 3'h1;
		end else begin
			div_r <= div_r + 32'h1;
		end
	end
	logic hz4;
	logic hz2;
	logic hz1;
	assign hz4 = blink_r[0];
	assign hz2 = blink_r[1];
	assign hz1 = blink_r[2];

	////////////////////////////////////////////////////////////////////////////
	// Registers and AXI4-Lite slave; the block only answers requests
	logic [2:0]        ctrl_r;
	logic [2:0]        fault_r;
	logic [2:0]        diag_r;
	logic              aw_have_r;
	logic              w_have_r;
	logic [AXI_AW-1:0] aw_addr_r;
	logic [31:0]       w_data_r;
	logic              w_en_r;
	logic              do_write;
	assign S_AXI_AWREADY = !aw_have_r && !S_AXI_BVALID;
	assign S_AXI_WREADY  = !w_have_r && !S_AXI_BVALID;
	assign S_AXI_ARREADY = !S_AXI_RVALID;
	assign do_write      = aw_have_r && w_have_r && !S_AXI_BVALID;

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			aw_have_r    <= 1'b0;
			w_have_r     <= 1'b0;
			aw_addr_r    <= '0;
			w_data_r     <= 32'h0;
			w_en_r       <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_have_r <= 1'b1;
				w_data_r <= S_AXI_WDATA;
				w_en_r   <= S_AXI_WSTRB[0];
			end
			if (do_write) begin
				aw_have_r    <= 1'b0;
				w_have_r     <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= reg_hit(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// Fault bits only ever set; nothing but a power cycle clears them
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ctrl_r  <= CTRL_RST;
			fault_r <= FAULT_RST;
			diag_r  <= DIAG_RST;
		end else if (do_write && w_en_r) begin
			if (aw_addr_r == OFS_CTRL)
				ctrl_r <= w_data_r[2:0];
			if (aw_addr_r == OFS_FAULT)
				fault_r <= fault_r | w_data_r[2:0];
			if (aw_addr_r == OFS_DIAG)
				diag_r <= w_data_r[2:0];
		end
	end

	logic [31:0] rd_word;
	always_comb begin
		rd_word = 32'h0;
		case (S_AXI_ARADDR)
			OFS_STATUS: begin
				rd_word[ST_NODE_LSB +: 7] = node_r;
				rd_word[ST_NODE_OK]       = node_ok_r;
				rd_word[ST_RATE_LSB +: 4] = rate_r;
				rd_word[ST_RATE_LOCK]     = lock_r;
				rd_word[ST_CAPTURED]      = cap_r == CAP_HELD;
			end
			OFS_CTRL:  rd_word[2:0] = ctrl_r;
			OFS_FAULT: rd_word[2:0] = fault_r;
			OFS_DIAG:  rd_word[2:0] = diag_r;
			default:   rd_word = 32'h0;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA  <= 32'h0;
			S_AXI_RRESP  <= RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA  <= rd_word;
			S_AXI_RRESP  <= reg_hit(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Indicators, registered; hardware faults outrank initialisation state
	logic addr_bad;
	assign addr_bad = !node_ok_r || ctrl_r[CT_INSTALL];
	fbs_led_t led_nxt;
	always_comb begin
		led_nxt = '0;
		if (fault_r[FL_ASIC_FLASH])
			led_nxt.status_red = hz2;
		else if (fault_r[FL_RAM])
			led_nxt.status_red = hz1;
		else if (fault_r[FL_DPRAM])
			led_nxt.status_red = hz4;
		else if (!ctrl_r[CT_INIT_DONE])
			led_nxt.status_green = hz2;
		else
			led_nxt.status_green = hz1;
		if (diag_r[DG_CHIP_EN])
			led_nxt.diag_red = hz4;
		else if (diag_r[DG_USER_PRM])
			led_nxt.diag_red = hz2;
		else if (diag_r[DG_IO_SIZE])
			led_nxt.diag_red = hz1;
		if (cap_r == CAP_HELD && addr_bad) begin
			led_nxt.online_green = hz2;
			led_nxt.offline_red  = hz2;
		end else begin
			led_nxt.online_green = ctrl_r[CT_ONLINE];
			led_nxt.offline_red  = !ctrl_r[CT_ONLINE];
		end
	end

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN)
			LED <= '0;
		else
			LED <= led_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);

	a_node_frozen: assert property (cap_r == CAP_HELD |=> $stable(node_r))
		else $error("node address changed after capture");
	a_node_sum: assert property ($rose(cap_r == CAP_HELD) |->
		node_r == 7'(TENS_WEIGHT * 7'($past(tens_s))) + 7'($past(units_s)))
		else $error("node address not ten times left plus right");
	a_fault_sticky: assert property (fault_r[FL_RAM] |=> fault_r[FL_RAM])
		else $error("hardware fault bit cleared");
	a_status_red2: assert property (fault_r[FL_ASIC_FLASH] |=> LED.status_red == $past(hz2))
		else $error("status LED not red at 2 Hz on chip fault");
	a_status_green1: assert property (fault_r == 3'h0 && ctrl_r[CT_INIT_DONE]
		|=> LED.status_green == $past(hz1) && !LED.status_red)
		else $error("status LED not green at 1 Hz");
	a_diag_dark: assert property (diag_r == 3'h0 ##1 diag_r == 3'h0 |-> !LED.diag_red)
		else $error("diagnostics LED lit without fault");
	a_line_leds: assert property (cap_r == CAP_HELD && !addr_bad |=>
		LED.online_green != LED.offline_red)
		else $error("on-line and off-line LEDs agree");
	a_blink_ratio: assert property ($rose(hz2) |-> hz1 == $past(hz1))
		else $error("blink divider stages out of step");
	a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read not answered next cycle");
	a_write_resp: assert property (do_write |=> S_AXI_BVALID ##0
		S_AXI_BRESP == (reg_hit($past(aw_addr_r)) ? RESP_OKAY : RESP_SLVERR))
		else $error("write response wrong");
	a_rate_range: assert property (lock_r |-> rate_r < 4'(NUM_RATES))
		else $error("bit rate index out of range");
endmodule

// ---- verif/fbs_bus_master_model.sv ----
// Bus master stand-in: toggles the bus line at one fixed bit time per burst.
// Assumes the bench calls send from its main process, one burst at a time.
module fbs_bus_master_model (
	// Clock
	input  wire logic clk,
	// Bus line
	output logic      rx
);
	timeunit 1ns;
	timeprecision 1ps;
	// Line rests high when idle, as the biased line does
	initial rx = 1'b1;
	////////////////////////////////////////////////////////////////////////////////
	// Even edge counts leave the line high, so no short run trails a burst
	task automatic send(input int bit_cyc, input int edges);
		for (int i = 0; i < edges; i++) begin
			repeat (bit_cyc) @(posedge clk);
			rx <= ~rx;
		end
		@(posedge clk);
		rx <= 1'b1;
	endtask
endmodule

// ---- verif/fbs_top_tb.sv ----
// Self-checking bench for the fieldbus slave configuration and status block.
// Assumes a shortened blink divider and a bus peer that only drives the line.
module fbs_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import fbs_pkg::*;
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
	localparam int HF = 4;
	localparam int SR = 4, SG = 3, DR = 2, ON = 1, OF = 0;
	logic        clk = 1'b0, rstn, awv, wv, bre, arv, rre;
	logic [3:0]  awa, ara, wst, tens, units;
	logic [31:0] wd, rd;
	logic [1:0]  rsp;
	wire         awr, wr_rdy, bv, arr, rv, rx;
	wire [1:0]   bresp, rresp;
	wire [31:0]  rdata;
	fbs_led_t    led;
	int          err_count = 0, cmp_count = 0;
	always #2 clk = ~clk;
	fbs_top #(.HALF_FAST(HF)) DUT (.REF_CLK(clk), .RSTN(rstn), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(wst), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_rdy),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
		.S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre),
		.SW_TENS(tens), .SW_UNITS(units), .BUS_RX(rx), .LED(led));
	fbs_bus_master_model PEER (.clk(clk), .rx(rx));
	////////////////////////////////////////////////////////////////////////////////
	// Handshakes judged at the negedge, so the edge itself never races
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		bit ha, hw, hb;
		int n;
		n = 0;
		hb = 0;
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		while (!hb && n < 100) begin
			@(negedge clk);
			ha = awv && awr;
			hw = wv && wr_rdy;
			hb = bv && bre;
			if (hb) rsp = bresp;
			@(posedge clk);
			if (ha) awv <= 1'b0;
			if (hw) wv <= 1'b0;
			n++;
		end
		`CHK({hb, rsp}, {1'b1, er})
	endtask
	task automatic rdr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		bit hr, hv;
		int n;
		n = 0;
		hv = 0;
		d = 'x;
		r = 'x;
		ara <= a;
		arv <= 1'b1;
		while (!hv && n < 100) begin
			@(negedge clk);
			hr = arv && arr;
			hv = rv && rre;
			if (hv) d = rdata;
			if (hv) r = rresp;
			@(posedge clk);
			if (hr) arv <= 1'b0;
			n++;
		end
	endtask
	task automatic chk_rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		rdr(a, rd, rsp);
		`CHK({rsp, rd & m}, {RESP_OKAY, e})
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Skips two cycles so a pattern switch does not count as a half period
	task automatic blink(input int b, input int h);
		logic v;
		int n;
		n = 0;
		repeat (2) @(negedge clk);
		v = led[b];
		while (led[b] === v && n < 100) begin
			@(negedge clk);
			n++;
		end
		repeat (2) begin
			v = led[b];
			n = 0;
			while (led[b] === v && n < 100) begin
				@(negedge clk);
				n++;
			end
			`CHK(n, h)
		end
		@(posedge clk);
	endtask
	task automatic steady(input int b, input logic e);
		int bad;
		bad = 0;
		repeat (2) @(negedge clk);
		repeat (40) begin
			@(negedge clk);
			if (led[b] !== e) bad++;
		end
		@(posedge clk);
		`CHK(bad, 0)
	endtask
	task automatic wr_blink(input logic [3:0] a, input logic [31:0] d, input int b, input int h);
		wr(a, d, RESP_OKAY);
		blink(b, h);
	endtask
	task automatic do_reset(input logic [3:0] t, input logic [3:0] u);
		rstn <= 1'b0;
		tens <= t;
		units <= u;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		repeat (8) @(posedge clk);
	endtask
	task automatic report_and_stop;
		$display("errors=%0d compares=%0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (60000) @(posedge clk);
		err_count++;
		report_and_stop();
	end
	// Scenarios
	task automatic sc_startup;
		do_reset(4'h4, 4'h2);
		blink(SG, 2 * HF);
		steady(OF, 1'b1);
		steady(ON, 1'b0);
		steady(DR, 1'b0);
		chk_rd(OFS_STATUS, 32'h20ff, 32'h20aa);
	endtask
	task automatic sc_capture_hold;
		tens <= 4'h9;
		units <= 4'h9;
		repeat (10) @(posedge clk);
		chk_rd(OFS_STATUS, 32'h20ff, 32'h20aa);
	endtask
	task automatic sc_line_leds;
		wr_blink(OFS_CTRL, 32'h7, ON, 2 * HF);
		blink(OF, 2 * HF);
		wr_blink(OFS_CTRL, 32'h3, SG, 4 * HF);
		steady(ON, 1'b1);
		steady(OF, 1'b0);
	endtask
	task automatic sc_diag;
		wr_blink(OFS_DIAG, 32'h1, DR, 4 * HF);
		wr_blink(OFS_DIAG, 32'h2, DR, 2 * HF);
		wr_blink(OFS_DIAG, 32'h4, DR, HF);
		wr(OFS_DIAG, 32'h0, RESP_OKAY);
		steady(DR, 1'b0);
	endtask
	// Unmapped offsets answer with an error and change nothing
	task automatic sc_bus_errors;
		rdr(4'h2, rd, rsp);
		`CHK({rsp, rd}, {RESP_SLVERR, 32'h0})
		wr(4'h6, 32'h7, RESP_SLVERR);
		chk_rd(OFS_CTRL, 32'h7, 32'h3);
	endtask
	task automatic sc_faults;
		wr_blink(OFS_FAULT, 32'h4, SR, HF);
		wr_blink(OFS_FAULT, 32'h2, SR, 4 * HF);
		wr_blink(OFS_FAULT, 32'h1, SR, 2 * HF);
		wr(OFS_FAULT, 32'h0, RESP_OKAY);
		chk_rd(OFS_FAULT, 32'h7, 32'h7);
		blink(SR, 2 * HF);
	endtask
	// One rate per burst; the second burst needs a full clean window
	task automatic sc_rate;
		PEER.send(21, 70);
		chk_rd(OFS_STATUS, 32'h1f00, 32'h1900);
		PEER.send(500, 70);
		chk_rd(OFS_STATUS, 32'h1f00, 32'h1500);
	endtask
	task automatic sc_power_cycle;
		do_reset(4'h0, 4'h0);
		chk_rd(OFS_FAULT, 32'h7, 32'h0);
		chk_rd(OFS_STATUS, 32'h20ff, 32'h2000);
		blink(ON, 2 * HF);
		blink(OF, 2 * HF);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Response readies stay high, so back-to-back calls never re-drive them
	initial begin
		awv <= 1'b0;
		wv <= 1'b0;
		bre <= 1'b1;
		arv <= 1'b0;
		rre <= 1'b1;
		awa <= 4'h0;
		ara <= 4'h0;
		wd <= 32'h0;
		wst <= 4'hf;
		sc_startup();
		sc_capture_hold();
		sc_line_leds();
		sc_diag();
		sc_bus_errors();
		sc_faults();
		sc_rate();
		sc_power_cycle();
		report_and_stop();
	end
endmodule
